//--- logic/ser_pkg.sv
// constants and types of the status and event reporting unit
package ser_pkg;
  localparam int MASK_W = 8;
  localparam int CMD_DATA_W = 16;
  localparam int CODE_W = 16;
  localparam int MSG_W = 6;
  localparam int MOD_W = 4;
  localparam int QUEUE_DEPTH = 10;
  localparam int REC_W = CODE_W + MSG_W + MOD_W;

  // event latch bit positions
  localparam int BIT_OPDONE = 0;
  localparam int BIT_QUERY = 2;
  localparam int BIT_DEVDEP = 3;
  localparam int BIT_EXEC = 4;
  localparam int BIT_CMD = 5;
  localparam int BIT_PWRON = 7;

  // summary byte bit positions
  localparam int SUM_QUEUE = 2;
  localparam int SUM_MAV = 4;
  localparam int SUM_EVENT = 5;
  localparam int SUM_MASTER = 6;
  localparam logic [7:0] SUM_USED = 8'h34;

  localparam logic [15:0] CMD_MASK_MAX = 16'h00ff;
  localparam logic [7:0] EVT_EN_RESET = 8'h00;
  localparam logic [7:0] SRQ_EN_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h80;

  // error codes, two's complement
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_SYNTAX = 16'hff9a;
  localparam logic [15:0] CODE_BAD_CHAR = 16'hff87;
  localparam logic [15:0] CODE_EXPONENT = 16'hff85;
  localparam logic [15:0] CODE_EXEC = 16'hff38;
  localparam logic [15:0] CODE_TRIG_IGN = 16'hff2d;
  localparam logic [15:0] CODE_INIT_IGN = 16'hff2b;
  localparam logic [15:0] CODE_RANGE = 16'hff22;
  localparam logic [15:0] CODE_TOO_MUCH = 16'hff21;
  localparam logic [15:0] CODE_SHIFT_REG = 16'hff10;
  localparam logic [15:0] CODE_UNKNOWN_MOD = 16'hff0f;
  localparam logic [15:0] CODE_QUEUE_OVF = 16'hfea2;

  // code classes, inclusive signed bounds
  localparam logic signed [15:0] CMD_CLASS_HI = 16'shff9c;
  localparam logic signed [15:0] CMD_CLASS_LO = 16'shff39;
  localparam logic signed [15:0] EXEC_CLASS_HI = 16'shff38;
  localparam logic signed [15:0] EXEC_CLASS_LO = 16'shfed5;
  localparam logic signed [15:0] DEV_CLASS_HI = 16'shfed4;
  localparam logic signed [15:0] DEV_CLASS_LO = 16'shfe71;

  // text ids of records made by this unit
  localparam logic [5:0] MSG_NONE = 6'h00;
  localparam logic [5:0] MSG_EVT_EN_RANGE = 6'h01;
  localparam logic [5:0] MSG_SRQ_EN_RANGE = 6'h02;
  localparam logic [5:0] MSG_ERR_QUEUE_OVF = 6'h03;
  localparam logic [5:0] MSG_OUT_QUEUE_OVF = 6'h04;
  localparam logic [3:0] MODULE_NONE = 4'h0;

  typedef enum logic [2:0] {
    CMD_SET_EVT_EN = 3'b000,
    CMD_GET_EVT_EN = 3'b001,
    CMD_SET_SRQ_EN = 3'b010,
    CMD_GET_SRQ_EN = 3'b011,
    CMD_READ_LATCH = 3'b100,
    CMD_READ_SUMMARY = 3'b101,
    CMD_READ_ERROR = 3'b110,
    CMD_NOP = 3'b111
  } ser_cmd_e;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [MSG_W-1:0] msg;
    logic [MOD_W-1:0] modIdx;
  } ser_rec_s;
endpackage : ser_pkg

//--- logic/ser_queue_if.sv
// link between the reporting unit and its error queue
`timescale 1ns/100ps
interface ser_queue_if #(
  parameter int WIDTH = ser_pkg::REC_W
);
  logic pushValid;
  logic [WIDTH-1:0] pushRec;
  logic [WIDTH-1:0] ovfRec;
  logic popReq;
  logic [WIDTH-1:0] headRec;
  logic empty;
  logic nextEmpty;
  logic full;

  modport owner (
    output pushValid, pushRec, ovfRec, popReq,
    input headRec, empty, nextEmpty, full
  );
  modport store (
    input pushValid, pushRec, ovfRec, popReq,
    output headRec, empty, nextEmpty, full
  );
endinterface : ser_queue_if

//--- logic/ser_event_queue.sv
// first-in first-out store for coded error and event records
`timescale 1ns/100ps
module ser_event_queue #(
  parameter int DEPTH = ser_pkg::QUEUE_DEPTH,
  parameter int WIDTH = ser_pkg::REC_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  ser_queue_if.store q
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W-1:0] wrPtr;
    logic [CNT_W-1:0] count;
  } ser_queue_s;

  ser_queue_s st;
  ser_queue_s next_st;
  logic doPop;
  logic doPush;
  logic doReplace;

  if (DEPTH < 2) begin : g_depth_check
    $error("queue depth must be at least two");
  end

  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    step = (p == LAST) ? '0 : PTR_W'(p + 1'b1);
  endfunction : step

  always_comb
  begin
    next_st = st;
    doPop = q.popReq && (st.count != '0);
    // a pop in the same cycle frees a slot for the push
    doPush = q.pushValid && ((st.count != FULL_COUNT) || doPop);
    doReplace = q.pushValid && !doPush;
    if (doPush)
    begin
      next_st.mem[st.wrPtr] = q.pushRec;
      next_st.wrPtr = step(st.wrPtr);
    end
    if (doReplace)
    begin
      // stored records stay, the newest one becomes the overflow record
      next_st.mem[(st.wrPtr == '0) ? LAST : PTR_W'(st.wrPtr - 1'b1)] =
        q.ovfRec;
    end
    if (doPop)
    begin
      next_st.rdPtr = step(st.rdPtr);
    end
    if (doPush && !doPop)
    begin
      next_st.count = CNT_W'(st.count + 1'b1);
    end
    else if (doPop && !doPush)
    begin
      next_st.count = CNT_W'(st.count - 1'b1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q.headRec = st.mem[st.rdPtr];
  assign q.empty = (st.count == '0);
  assign q.full = (st.count == FULL_COUNT);
  assign q.nextEmpty = (next_st.count == '0);

  a_queue_bound: assert property (@(posedge clk_sys) disable iff (rst)
    st.count <= FULL_COUNT)
    else $error("queue holds more records than its depth");

  a_queue_order: assert property (@(posedge clk_sys) disable iff (rst)
    q.pushValid && q.empty |=> q.headRec == $past(q.pushRec))
    else $error("first record pushed is not at the head");

  a_overflow_keeps: assert property (@(posedge clk_sys) disable iff (rst)
    q.pushValid && q.full && !q.popReq |=> q.full && $stable(st.rdPtr)
      && q.headRec == $past(q.headRec))
    else $error("overflow disturbed stored records");
endmodule : ser_event_queue

//--- logic/ser_status_reporting.sv
// status byte, event latch, masks and error queue front end
`timescale 1ns/100ps
module ser_status_reporting (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdValid,
  input wire ser_pkg::ser_cmd_e cmdOp,
  input wire logic [15:0] cmdData,
  input wire logic evtValid,
  input wire logic [15:0] evtCode,
  input wire logic [5:0] evtMsg,
  input wire logic [3:0] evtModule,
  input wire logic opDoneEvt,
  input wire logic queryLostEvt,
  input wire logic outQueuePut,
  input wire logic outQueueDrained,
  input wire logic outQueueOverflow,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic [15:0] rspCode,
  output logic [5:0] rspMsg,
  output logic [3:0] rspModule,
  output logic [7:0] statusByte,
  output logic serviceRequest
);
  typedef struct packed {
    logic [7:0] evtEn;
    logic [7:0] srqEn;
    logic [7:0] latch;
    logic mav;
    logic rspValid;
    logic [7:0] rspData;
    logic [15:0] rspCode;
    logic [5:0] rspMsg;
    logic [3:0] rspModule;
    logic [7:0] summary;
    logic srq;
  } ser_top_s;

  ser_top_s st;
  ser_top_s next_st;
  ser_queue_if #(.WIDTH(ser_pkg::REC_W)) qi ();

  logic [7:0] latchSet;
  logic latchClear;
  logic rangeBad;
  logic cmdPush;
  logic eventBit;
  logic masterBit;
  ser_pkg::ser_rec_s cmdRec;
  ser_pkg::ser_rec_s evtRec;
  ser_pkg::ser_rec_s oqRec;
  ser_pkg::ser_rec_s eqRec;
  ser_pkg::ser_rec_s head;

  ser_event_queue #(
    .DEPTH(ser_pkg::QUEUE_DEPTH),
    .WIDTH(ser_pkg::REC_W)
  ) u_queue (
    .clk_sys(clk_sys),
    .rst(rst),
    .q(qi.store)
  );

  // latch bit that a reported code belongs to
  function automatic logic [7:0] code_class(input logic [15:0] code);
    logic signed [15:0] c;
    c = signed'(code);
    code_class = '0;
    if (c <= ser_pkg::CMD_CLASS_HI && c >= ser_pkg::CMD_CLASS_LO)
    begin
      code_class[ser_pkg::BIT_CMD] = 1'b1;
    end
    else if (c <= ser_pkg::EXEC_CLASS_HI && c >= ser_pkg::EXEC_CLASS_LO)
    begin
      // covers -200..-299 including -223 and -240/-241
      code_class[ser_pkg::BIT_EXEC] = 1'b1;
    end
    else if (c <= ser_pkg::DEV_CLASS_HI && c >= ser_pkg::DEV_CLASS_LO)
    begin
      code_class[ser_pkg::BIT_DEVDEP] = 1'b1;
    end
  endfunction : code_class

  assign head = ser_pkg::ser_rec_s'(qi.headRec);

  always_comb
  begin
    next_st = st;
    next_st.rspValid = 1'b0;
    latchSet = '0;
    latchClear = 1'b0;
    cmdPush = 1'b0;
    qi.popReq = 1'b0;
    rangeBad = (cmdData > ser_pkg::CMD_MASK_MAX);
    cmdRec = '{ser_pkg::CODE_RANGE, ser_pkg::MSG_EVT_EN_RANGE,
      ser_pkg::MODULE_NONE};
    // module index comes from the source: 1 is the interface board slot
    evtRec = '{evtCode, evtMsg, evtModule};
    oqRec = '{ser_pkg::CODE_QUEUE_OVF, ser_pkg::MSG_OUT_QUEUE_OVF,
      ser_pkg::MODULE_NONE};
    eqRec = '{ser_pkg::CODE_QUEUE_OVF, ser_pkg::MSG_ERR_QUEUE_OVF,
      ser_pkg::MODULE_NONE};

    if (evtValid)
    begin
      latchSet = latchSet | code_class(evtCode);
    end
    if (opDoneEvt)
    begin
      latchSet[ser_pkg::BIT_OPDONE] = 1'b1;
    end
    if (queryLostEvt)
    begin
      latchSet[ser_pkg::BIT_QUERY] = 1'b1;
    end
    if (outQueueOverflow)
    begin
      latchSet[ser_pkg::BIT_DEVDEP] = 1'b1;
    end

    if (cmdValid)
    begin
      case (cmdOp)
        ser_pkg::CMD_SET_EVT_EN:
        begin
          if (rangeBad)
          begin
            cmdPush = 1'b1;
            latchSet[ser_pkg::BIT_EXEC] = 1'b1;
          end
          else
          begin
            next_st.evtEn = cmdData[7:0];
          end
        end
        ser_pkg::CMD_SET_SRQ_EN:
        begin
          if (rangeBad)
          begin
            cmdPush = 1'b1;
            cmdRec.msg = ser_pkg::MSG_SRQ_EN_RANGE;
            latchSet[ser_pkg::BIT_EXEC] = 1'b1;
          end
          else
          begin
            next_st.srqEn = cmdData[7:0];
          end
        end
        ser_pkg::CMD_GET_EVT_EN:
        begin
          next_st.rspValid = 1'b1;
          next_st.rspData = st.evtEn;
          next_st.rspCode = ser_pkg::CODE_NONE;
          next_st.rspMsg = ser_pkg::MSG_NONE;
          next_st.rspModule = ser_pkg::MODULE_NONE;
        end
        ser_pkg::CMD_GET_SRQ_EN:
        begin
          next_st.rspValid = 1'b1;
          next_st.rspData = st.srqEn;
          next_st.rspCode = ser_pkg::CODE_NONE;
          next_st.rspMsg = ser_pkg::MSG_NONE;
          next_st.rspModule = ser_pkg::MODULE_NONE;
        end
        ser_pkg::CMD_READ_LATCH:
        begin
          next_st.rspValid = 1'b1;
          next_st.rspData = st.latch;
          next_st.rspCode = ser_pkg::CODE_NONE;
          next_st.rspMsg = ser_pkg::MSG_NONE;
          next_st.rspModule = ser_pkg::MODULE_NONE;
          latchClear = 1'b1;
        end
        ser_pkg::CMD_READ_SUMMARY:
        begin
          next_st.rspValid = 1'b1;
          next_st.rspData = st.summary;
          next_st.rspCode = ser_pkg::CODE_NONE;
          next_st.rspMsg = ser_pkg::MSG_NONE;
          next_st.rspModule = ser_pkg::MODULE_NONE;
        end
        ser_pkg::CMD_READ_ERROR:
        begin
          next_st.rspValid = 1'b1;
          next_st.rspData = '0;
          // an empty queue answers code 0, no error
          if (!qi.empty)
          begin
            next_st.rspCode = head.code;
            next_st.rspMsg = head.msg;
            next_st.rspModule = head.modIdx;
            qi.popReq = 1'b1;
          end
          else
          begin
            next_st.rspCode = ser_pkg::CODE_NONE;
            next_st.rspMsg = ser_pkg::MSG_NONE;
            next_st.rspModule = ser_pkg::MODULE_NONE;
          end
        end
        default:
        begin
        end
      endcase
    end

    // one record per cycle: refused write, then event, then output overflow
    qi.pushValid = cmdPush || evtValid || outQueueOverflow;
    if (cmdPush)
    begin
      qi.pushRec = cmdRec;
    end
    else if (evtValid)
    begin
      qi.pushRec = evtRec;
    end
    else
    begin
      qi.pushRec = oqRec;
    end
    qi.ovfRec = eqRec;
    if (qi.pushValid && qi.full && !qi.popReq)
    begin
      latchSet[ser_pkg::BIT_DEVDEP] = 1'b1;
    end

    // set wins over the clear of a read in the same cycle
    next_st.latch = (latchClear ? '0 : st.latch) | latchSet;
    next_st.mav = (outQueueDrained ? 1'b0 : st.mav) | outQueuePut;

    eventBit =
      (next_st.latch[ser_pkg::BIT_OPDONE] &
        next_st.evtEn[ser_pkg::BIT_OPDONE]) |
      (next_st.latch[ser_pkg::BIT_QUERY] &
        next_st.evtEn[ser_pkg::BIT_QUERY]) |
      (next_st.latch[ser_pkg::BIT_EXEC] &
        next_st.evtEn[ser_pkg::BIT_EXEC]) |
      (next_st.latch[ser_pkg::BIT_CMD] &
        next_st.evtEn[ser_pkg::BIT_CMD]) |
      (next_st.latch[ser_pkg::BIT_PWRON] &
        next_st.evtEn[ser_pkg::BIT_PWRON]);

    next_st.summary = '0;
    next_st.summary[ser_pkg::SUM_QUEUE] = !qi.nextEmpty;
    next_st.summary[ser_pkg::SUM_MAV] = next_st.mav;
    next_st.summary[ser_pkg::SUM_EVENT] = eventBit;
    masterBit = |(next_st.summary & next_st.srqEn & ser_pkg::SUM_USED);
    next_st.summary[ser_pkg::SUM_MASTER] = masterBit;
    next_st.srq = masterBit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st <= '0;
      st.evtEn <= ser_pkg::EVT_EN_RESET;
      st.srqEn <= ser_pkg::SRQ_EN_RESET;
      // power-on event is latched by reset
      st.latch <= ser_pkg::LATCH_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rspValid = st.rspValid;
  assign rspData = st.rspData;
  assign rspCode = st.rspCode;
  assign rspMsg = st.rspMsg;
  assign rspModule = st.rspModule;
  assign statusByte = st.summary;
  assign serviceRequest = st.srq;

  a_event_summary: assert property (@(posedge clk_sys) disable iff (rst)
    statusByte[ser_pkg::SUM_EVENT] ==
      |(st.latch & st.evtEn & 8'hb5))
    else $error("event summary bit disagrees with latch and mask");

  a_mask_reject: assert property (@(posedge clk_sys) disable iff (rst)
    cmdValid && cmdOp == ser_pkg::CMD_SET_EVT_EN && cmdData > 16'h00ff
      |=> $stable(st.evtEn) && st.latch[ser_pkg::BIT_EXEC])
    else $error("out of range mask write was not refused");

  a_mask_readback: assert property (@(posedge clk_sys) disable iff (rst)
    cmdValid && cmdOp == ser_pkg::CMD_SET_EVT_EN && cmdData <= 16'h00ff
      ##1 cmdValid && cmdOp == ser_pkg::CMD_GET_EVT_EN
      |=> rspValid && {8'h00, rspData} == $past(cmdData, 2))
    else $error("mask read back differs from value written");

  a_latch_clear: assert property (@(posedge clk_sys) disable iff (rst)
    cmdValid && cmdOp == ser_pkg::CMD_READ_LATCH && latchSet == '0
      |=> st.latch == '0 && rspData == $past(st.latch))
    else $error("latch read did not return and clear its bits");

  a_mav_set: assert property (@(posedge clk_sys) disable iff (rst)
    outQueuePut |=> statusByte[ser_pkg::SUM_MAV])
    else $error("message available not set after output put");

  a_service_req: assert property (@(posedge clk_sys) disable iff (rst)
    serviceRequest == |(statusByte & st.srqEn & 8'h34) &&
      statusByte[ser_pkg::SUM_MASTER] == serviceRequest)
    else $error("service request disagrees with enabled summary bits");

  a_error_read: assert property (@(posedge clk_sys) disable iff (rst)
    cmdValid && cmdOp == ser_pkg::CMD_READ_ERROR && !qi.empty
      |=> rspValid && rspCode == $past(head.code))
    else $error("error read did not return the head record");

  a_cmd_class: assert property (@(posedge clk_sys) disable iff (rst)
    evtValid && (evtCode == 16'hff9a || evtCode == 16'hff87 ||
      evtCode == 16'hff85) |=> st.latch[ser_pkg::BIT_CMD])
    else $error("parse error code did not set command error bit");

  a_queue_flag: assert property (@(posedge clk_sys) disable iff (rst)
    evtValid |=> statusByte[ser_pkg::SUM_QUEUE])
    else $error("queued event did not show in summary byte");
endmodule : ser_status_reporting

//--- tb/ser_host_model.sv
// host side model that issues commands and collects the answers
`timescale 1ns/100ps
module ser_host_model (
  input wire logic clk_sys,
  output logic cmdValid,
  output ser_pkg::ser_cmd_e cmdOp,
  output logic [15:0] cmdData,
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic [ser_pkg::REC_W-1:0] rspRec
);
  initial
  begin
    cmdValid = 1'b0;
    cmdOp = ser_pkg::CMD_NOP;
    cmdData = 16'h0000;
  end

  // one command; the answer is taken in the cycle after the taking edge
  task automatic issue(input ser_pkg::ser_cmd_e op, input logic [15:0] val,
    output logic got, output logic [7:0] dat,
    output logic [ser_pkg::REC_W-1:0] rec);
    @(posedge clk_sys);
    #1;
    cmdValid = 1'b1;
    cmdOp = op;
    cmdData = val;
    @(posedge clk_sys);
    #1;
    cmdValid = 1'b0;
    cmdOp = ser_pkg::CMD_NOP;
    // released data shows a changed value, not the old one
    cmdData = ~val;
    got = rspValid;
    dat = rspData;
    rec = rspRec;
  endtask : issue

  // event mask write and read taken on two edges in a row
  task automatic issue_pair(input logic [15:0] val, output logic got,
    output logic [7:0] dat);
    @(posedge clk_sys);
    #1;
    cmdValid = 1'b1;
    cmdOp = ser_pkg::CMD_SET_EVT_EN;
    cmdData = val;
    @(posedge clk_sys);
    #1;
    cmdOp = ser_pkg::CMD_GET_EVT_EN;
    cmdData = ~val;
    @(posedge clk_sys);
    #1;
    cmdValid = 1'b0;
    cmdOp = ser_pkg::CMD_NOP;
    got = rspValid;
    dat = rspData;
  endtask : issue_pair
endmodule : ser_host_model

//--- tb/tb_ser_status_reporting.sv
// self-checking bench for the status and event reporting unit
`timescale 1ns/100ps
module tb_ser_status_reporting;
  localparam int RW = ser_pkg::REC_W;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cmdValid;
  ser_pkg::ser_cmd_e cmdOp;
  logic [15:0] cmdData;
  logic evtValid = 1'b0;
  logic [15:0] evtCode = 16'h0000;
  logic [5:0] evtMsg = 6'h00;
  logic [3:0] evtModule = 4'h0;
  logic opDoneEvt = 1'b0;
  logic queryLostEvt = 1'b0;
  logic outQueuePut = 1'b0;
  logic outQueueDrained = 1'b0;
  logic outQueueOverflow = 1'b0;
  logic rspValid;
  logic [7:0] rspData;
  logic [15:0] rspCode;
  logic [5:0] rspMsg;
  logic [3:0] rspModule;
  logic [7:0] statusByte;
  logic serviceRequest;
  int errors = 0;
  int samples_checked = 0;
  integer seed = 32'h9ffb7cc7;
  logic [7:0] mEvtEn = 8'h00;
  logic [7:0] mSrqEn = 8'h00;
  logic [7:0] mLatch = 8'h80;
  logic mMav = 1'b0;
  logic [RW-1:0] mQ[$];
  logic got;
  logic [7:0] dat;
  logic [RW-1:0] rec;
  logic [31:0] r;
  int bits[4] = '{0, 2, 4, 5};
  int kinds[4] = '{0, 1, 2, 2};
  logic [15:0] codes[10] = '{16'hff9a, 16'hff87, 16'hff85, 16'hff38,
    16'hff2d, 16'hff2b, 16'hff22, 16'hff21, 16'hff10, 16'hff0f};
  // codes that go with the latch bit of each step of the mask loop
  logic [15:0] loopCodes[4] = '{16'h0000, 16'h0000, 16'hff38, 16'hff9a};

  always #25 clk_sys = ~clk_sys;

  ser_status_reporting dut (
    .clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdData(cmdData), .evtValid(evtValid), .evtCode(evtCode),
    .evtMsg(evtMsg), .evtModule(evtModule), .opDoneEvt(opDoneEvt),
    .queryLostEvt(queryLostEvt), .outQueuePut(outQueuePut),
    .outQueueDrained(outQueueDrained), .outQueueOverflow(outQueueOverflow),
    .rspValid(rspValid), .rspData(rspData), .rspCode(rspCode),
    .rspMsg(rspMsg), .rspModule(rspModule), .statusByte(statusByte),
    .serviceRequest(serviceRequest)
  );

  ser_host_model host (
    .clk_sys(clk_sys), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
    .rspRec({rspCode, rspMsg, rspModule})
  );

  function automatic logic [7:0] exp_status();
    logic [7:0] s;
    s = 8'h00;
    s[2] = mQ.size() != 0;
    s[4] = mMav;
    s[5] = |(mLatch & mEvtEn & 8'hb5);
    s[6] = |(s & mSrqEn & 8'h34);
    return s;
  endfunction : exp_status

  // a full queue keeps its records and turns the newest into an overflow
  function automatic void push(logic [15:0] c, logic [5:0] m, logic [3:0] d);
    if (mQ.size() == 10)
    begin
      mQ[9] = {16'hfea2, 6'h03, 4'h0};
      mLatch[3] = 1'b1;
    end
    else
      mQ.push_back({c, m, d});
  endfunction : push

  task automatic check8(input string what, input logic [7:0] exp,
    input logic [7:0] act);
    samples_checked++;
    if (act !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, act);
    end
  endtask : check8

  task automatic check_rec(input logic [RW-1:0] exp, input logic [RW-1:0] act);
    samples_checked++;
    if (act !== exp)
    begin
      errors++;
      $display("Error queue record expected %h seen %h", exp, act);
    end
  endtask : check_rec

  task automatic check_status();
    logic [7:0] e;
    e = exp_status();
    check8("status byte", e, statusByte);
    check8("service request", {7'h0, e[6]},
      {7'h0, serviceRequest});
  endtask : check_status

  // kind: 0 done, 1 query lost, 2 coded, 3 put, 4 drained, 5 out overflow
  task automatic fire(input int kind, input logic [15:0] c,
    input logic [3:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    evtCode = c;
    evtMsg = c[5:0];
    evtModule = d;
    {outQueueOverflow, outQueueDrained, outQueuePut, evtValid, queryLostEvt,
      opDoneEvt} = 6'(1 << kind);
    @(posedge clk_sys);
    #1;
    {outQueueOverflow, outQueueDrained, outQueuePut, evtValid, queryLostEvt,
      opDoneEvt} = 6'h00;
    evtCode = ~c;
    n = -int'($signed(c));
    case (kind)
      0: mLatch[0] = 1'b1;
      1: mLatch[2] = 1'b1;
      2:
      begin
        mLatch[5] |= (n >= 100 && n < 200);
        mLatch[4] |= (n >= 200 && n < 300);
        mLatch[3] |= (n >= 300 && n < 400);
        push(c, c[5:0], d);
      end
      3: mMav = 1'b1;
      4: mMav = 1'b0;
      default:
      begin
        mLatch[3] = 1'b1;
        push(16'hfea2, 6'h04, 4'h0);
      end
    endcase
    check_status();
  endtask : fire

  task automatic cmd(input ser_pkg::ser_cmd_e op, input logic [15:0] val);
    logic rd;
    rd = op[0] || op == ser_pkg::CMD_READ_LATCH;
    rd = (rd || op == ser_pkg::CMD_READ_ERROR) && op != ser_pkg::CMD_NOP;
    host.issue(op, val, got, dat, rec);
    check8("answer strobe", {7'h0, rd}, {7'h0, got});
    case (op)
      ser_pkg::CMD_SET_EVT_EN, ser_pkg::CMD_SET_SRQ_EN:
        if (val > 16'h00ff)
        begin
          mLatch[4] = 1'b1;
          push(16'hff22, op[1] ? 6'h02 : 6'h01, 4'h0);
        end
        else if (op[1])
          mSrqEn = val[7:0];
        else
          mEvtEn = val[7:0];
      ser_pkg::CMD_GET_EVT_EN: check8("event mask", mEvtEn, dat);
      ser_pkg::CMD_GET_SRQ_EN: check8("service mask", mSrqEn, dat);
      ser_pkg::CMD_READ_LATCH:
      begin
        check8("event latch", mLatch, dat);
        mLatch = 8'h00;
      end
      ser_pkg::CMD_READ_SUMMARY:
        check8("summary", exp_status(), dat);
      ser_pkg::CMD_READ_ERROR:
        check_rec(mQ.size() ? mQ.pop_front() : '0, rec);
      default: ;
    endcase
    @(posedge clk_sys);
    #1;
    check_status();
  endtask : cmd

  task automatic drain();
    while (mQ.size() != 0)
      cmd(ser_pkg::CMD_READ_ERROR, 16'h0000);
    cmd(ser_pkg::CMD_READ_ERROR, 16'h0000);
  endtask : drain

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check_status();
    cmd(ser_pkg::CMD_SET_SRQ_EN, 16'h0034);
    cmd(ser_pkg::CMD_SET_EVT_EN, 16'h0080);
    cmd(ser_pkg::CMD_READ_LATCH, 16'h0000);
    cmd(ser_pkg::CMD_READ_LATCH, 16'h0000);
    $display("test power_on done");
    for (int i = 0; i < 4; i++)
    begin
      cmd(ser_pkg::CMD_SET_EVT_EN, 16'(1 << bits[i]));
      fire(kinds[(i + 1) % 4], loopCodes[(i + 1) % 4], 4'h1);
      fire(kinds[i], loopCodes[i], 4'h2);
      cmd(ser_pkg::CMD_READ_LATCH, 16'h0000);
    end
    cmd(ser_pkg::CMD_SET_EVT_EN, 16'h00ff);
    cmd(ser_pkg::CMD_GET_EVT_EN, 16'h0000);
    host.issue_pair(16'h005a, got, dat);
    check8("answer strobe", 8'h01, {7'h0, got});
    mEvtEn = 8'h5a;
    check8("paired mask", mEvtEn, dat);
    check_status();
    cmd(ser_pkg::CMD_SET_EVT_EN, 16'h0100);
    cmd(ser_pkg::CMD_SET_SRQ_EN, 16'hffff);
    cmd(ser_pkg::CMD_GET_SRQ_EN, 16'h0000);
    drain();
    $display("test masks done");
    for (int i = 0; i < 10; i++)
      fire(2, codes[i], 4'(i + 1));
    fire(5, 16'h0000, 4'h0);
    fire(3, 16'h0000, 4'h0);
    cmd(ser_pkg::CMD_READ_LATCH, 16'h0000);
    drain();
    fire(4, 16'h0000, 4'h0);
    fire(5, 16'h0000, 4'h0);
    drain();
    $display("test queue done");
    for (int i = 0; i < 80; i++)
    begin
      r = $random(seed);
      if (r[31])
        cmd(ser_pkg::ser_cmd_e'(r[2:0]), {7'h00, r[16:8]});
      else
        fire(int'(r[30:28]) % 6, 16'(-100 - int'(r[15:8])), r[7:4]);
    end
    drain();
    $display("test random done");
    report_and_stop();
  end
endmodule : tb_ser_status_reporting
